/* hw/rse_exec.sv */
// Design decisions made here: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none
module rse_exec #(
   parameter int unsigned FILE_DEPTH = 128,
   parameter int unsigned WDT_W      = 8,
   parameter int unsigned PRE_W      = 8
) (
   input  wire logic                        clk_i,
   input  wire logic                        rstn_i,
   input  wire logic [rse_pkg::ADDR_W-1:0]  address_i,
   input  wire logic                        read_i,
   input  wire logic                        write_i,
   input  wire logic [rse_pkg::DATA_W-1:0]  writedata_i,
   input  wire logic [3:0]                  byteenable_i,
   output logic      [rse_pkg::DATA_W-1:0]  readdata_o,
   output logic                             waitrequest_o,
   input  wire logic                        wake_i,
   output logic                             sleep_o,
   output logic                             exec_done_o
);

   // Rotate through carry, result in [7:0], carry out in [8]
   function automatic logic [8:0] rot_through_carry(input logic [7:0] v, input logic c,
                                                    input logic left);
      if (left) begin
         rot_through_carry = {v[7], v[6:0], c};
      end else begin
         rot_through_carry = {v[0], c, v[7:1]};
      end
   endfunction

   // Byte-lane merge of a bus write into an old value
   function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                              input logic [3:0] be);
      lane_merge = old;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            lane_merge[i*8 +: 8] = nw[i*8 +: 8];
         end
      end
   endfunction

   // State
   logic [7:0]                file_mem [FILE_DEPTH];
   logic                      ack_q, ack_d;
   logic [31:0]               rdata_q, rdata_d;
   logic [13:0]               instr_q, instr_d;
   logic [7:0]                w_q, w_d;
   logic                      carry_q, carry_d;
   logic                      pdown_q, pdown_d;
   logic                      tmo_q, tmo_d;
   logic [WDT_W-1:0]          wdt_q, wdt_d;
   logic [PRE_W-1:0]          pre_q, pre_d;
   logic [6:0]                faddr_q, faddr_d;
   logic [1:0]                err_q, err_d;
   logic                      done_q, done_d;
   rse_pkg::rse_state_type    state_q, state_d;
   logic                      wake_s1_q, wake_s2_q;
   // Registered copies so that every output leaves a flop
   logic                      wreq_q, sleep_q;

   // Decode and datapath nets
   logic                      commit, wr, instr_wr;
   logic [31:0]               wmerge;
   logic [13:0]               op;
   logic                      is_rrf, is_rlf, is_sleep, is_rot, dest;
   logic [6:0]                f;
   logic [7:0]                src_val;
   logic [8:0]                rot_res;
   logic                      file_we;
   logic [6:0]                file_wa;
   logic [7:0]                file_wd;
   logic [31:0]               rd_mux;

   // Combined read mux, unmapped offsets read as zero
   always_comb begin
      rd_mux = '0;
      case (address_i)
         rse_pkg::OFS_INSTR:  rd_mux[13:0] = instr_q;
         rse_pkg::OFS_WREG:   rd_mux[7:0] = w_q;
         rse_pkg::OFS_STATUS: begin
            rd_mux[rse_pkg::ST_CARRY]   = carry_q;
            rd_mux[rse_pkg::ST_PDOWN]   = pdown_q;
            rd_mux[rse_pkg::ST_TIMEOUT] = tmo_q;
         end
         rse_pkg::OFS_WDOG:   rd_mux[15:0] = {8'(pre_q), 8'(wdt_q)};
         rse_pkg::OFS_SLEEP:  rd_mux[0] = (state_q == rse_pkg::ST_SLEEP);
         rse_pkg::OFS_FADDR:  rd_mux[6:0] = faddr_q;
         rse_pkg::OFS_FDATA:  rd_mux[7:0] = file_mem[faddr_q];
         rse_pkg::OFS_ERR:    rd_mux[1:0] = err_q;
         default:             rd_mux = '0;
      endcase
   end

   // Bus handshake: one wait cycle, commit on the cycle waitrequest is low
   always_comb begin
      ack_d   = (read_i | write_i) & ~ack_q;
      commit  = (read_i | write_i) & ack_q;
      wr      = commit & write_i;
      rdata_d = (ack_d & read_i) ? rd_mux : rdata_q;
      wmerge  = lane_merge(rd_mux, writedata_i, byteenable_i);
   end

   // Instruction decode; a write to the instruction port issues it
   always_comb begin
      op       = wmerge[13:0];
      is_rrf   = (op[13:rse_pkg::OPC_HI_POS] == rse_pkg::OPC_RRF);
      is_rlf   = (op[13:rse_pkg::OPC_HI_POS] == rse_pkg::OPC_RLF);
      is_sleep = (op == rse_pkg::OPC_SLEEP);
      is_rot   = is_rrf | is_rlf;
      dest     = op[rse_pkg::DEST_POS];
      f        = op[rse_pkg::FADR_W-1:0];
      src_val  = file_mem[f];
      rot_res  = rot_through_carry(src_val, carry_q, is_rlf);
      instr_wr = wr & (address_i == rse_pkg::OFS_INSTR) & (state_q == rse_pkg::ST_RUN);
   end

   // Execution and register next values
   always_comb begin
      instr_d = instr_q;
      w_d     = w_q;
      carry_d = carry_q;
      pdown_d = pdown_q;
      tmo_d   = tmo_q;
      faddr_d = faddr_q;
      err_d   = err_q;
      state_d = state_q;
      file_we = 1'b0;
      file_wa = faddr_q;
      file_wd = wmerge[7:0];
      done_d  = instr_wr;
      // Free-running watchdog time base, prescaler first
      pre_d   = pre_q + PRE_W'(1);
      wdt_d   = (pre_q == '1) ? wdt_q + WDT_W'(1) : wdt_q;
      // Software writes to plain registers
      if (wr) begin
         case (address_i)
            rse_pkg::OFS_WREG:   w_d = wmerge[7:0];
            rse_pkg::OFS_STATUS: carry_d = wmerge[rse_pkg::ST_CARRY];
            rse_pkg::OFS_FADDR:  faddr_d = wmerge[6:0];
            rse_pkg::OFS_FDATA:  file_we = 1'b1;
            rse_pkg::OFS_ERR:    err_d = err_q & ~wmerge[1:0];
            default: ;
         endcase
      end
      // Issue refused while asleep is flagged; set beats clear
      if (wr && (address_i == rse_pkg::OFS_INSTR) && (state_q == rse_pkg::ST_SLEEP)) begin
         err_d[rse_pkg::ERR_ASLEEP] = 1'b1;
      end
      if (instr_wr) begin
         instr_d = op;
         if (is_rot) begin
            carry_d = rot_res[8];
            if (dest) begin
               file_we = 1'b1;
               file_wa = f;
               file_wd = rot_res[7:0];
            end else begin
               w_d = rot_res[7:0];
            end
         end else if (is_sleep) begin
            wdt_d   = '0;
            pre_d   = '0;
            tmo_d   = 1'b1;
            pdown_d = 1'b0;
            state_d = rse_pkg::ST_SLEEP;
         end else begin
            err_d[rse_pkg::ERR_BADOP] = 1'b1;
         end
      end
      // Wake by pin or by software; the sleep issue itself wins over a wake
      if ((state_q == rse_pkg::ST_SLEEP) &&
          (wake_s2_q || (wr && (address_i == rse_pkg::OFS_SLEEP) && !wmerge[0]))) begin
         state_d = rse_pkg::ST_RUN;
      end
   end

   // Wake pin crosses in from outside, two flops before use
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         wake_s1_q <= 1'b0;
         wake_s2_q <= 1'b0;
      end else begin
         wake_s1_q <= wake_i;
         wake_s2_q <= wake_s1_q;
      end
   end

   // File array has no reset; software must initialise it
   always_ff @(posedge clk_i) begin
      if (file_we) begin
         file_mem[file_wa] <= file_wd;
      end
   end

   // Control and data registers
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ack_q   <= 1'b0;
         rdata_q <= '0;
         instr_q <= rse_pkg::RST_INSTR;
         w_q     <= rse_pkg::RST_WREG;
         carry_q <= rse_pkg::RST_CARRY;
         pdown_q <= rse_pkg::RST_PDOWN;
         tmo_q   <= rse_pkg::RST_TIMEOUT;
         wdt_q   <= '0;
         pre_q   <= '0;
         faddr_q <= rse_pkg::RST_FADDR;
         err_q   <= '0;
         done_q  <= 1'b0;
         state_q <= rse_pkg::ST_RUN;
         wreq_q  <= 1'b1;
         sleep_q <= 1'b0;
      end else begin
         ack_q   <= ack_d;
         rdata_q <= rdata_d;
         instr_q <= instr_d;
         w_q     <= w_d;
         carry_q <= carry_d;
         pdown_q <= pdown_d;
         tmo_q   <= tmo_d;
         wdt_q   <= wdt_d;
         pre_q   <= pre_d;
         faddr_q <= faddr_d;
         err_q   <= err_d;
         done_q  <= done_d;
         state_q <= state_d;
         wreq_q  <= ~ack_d;
         sleep_q <= (state_d == rse_pkg::ST_SLEEP);
      end
   end

   // Outputs straight from flops; waitrequest idles high
   assign readdata_o    = rdata_q;
   assign waitrequest_o = wreq_q;
   assign sleep_o       = sleep_q;
   assign exec_done_o   = done_q;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   AST_RRF_RESULT: assert property (
      instr_wr && is_rrf && !dest |=>
         w_q == {$past(carry_q), $past(src_val[7:1])} && carry_q == $past(src_val[0]))
      else $error("rotate right result or carry wrong");

   AST_RLF_RESULT: assert property (
      instr_wr && is_rlf && !dest |=>
         w_q == {$past(src_val[6:0]), $past(carry_q)} && carry_q == $past(src_val[7]))
      else $error("rotate left result or carry wrong");

   AST_ROT_FLAGS: assert property (
      instr_wr && is_rot |=> $stable(tmo_q) && $stable(pdown_q) && state_q == rse_pkg::ST_RUN)
      else $error("rotate disturbed other status");

   AST_DEST_W: assert property (
      instr_wr && is_rot && !dest |-> !file_we)
      else $error("rotate to accumulator wrote the file");

   AST_DEST_F: assert property (
      instr_wr && is_rot && dest |=>
         file_mem[$past(f)] == $past(rot_res[7:0]) && $stable(w_q))
      else $error("rotate to file wrong");

   AST_SLEEP_EFFECT: assert property (
      instr_wr && is_sleep |=> wdt_q == '0 && pre_q == '0 && tmo_q && !pdown_q)
      else $error("sleep did not reset watchdog or status");

   AST_ONE_CYCLE: assert property (
      instr_wr |=> exec_done_o ##1 !exec_done_o || $past(instr_wr))
      else $error("instruction did not complete in one cycle");

   AST_HALTED: assert property (
      state_q == rse_pkg::ST_SLEEP && wr && address_i == rse_pkg::OFS_INSTR |=>
         !exec_done_o && err_q[rse_pkg::ERR_ASLEEP])
      else $error("instruction executed while asleep");

   // File-bound rotates must move the carry just as the accumulator path does
   AST_RRF_FILE: assert property (
      instr_wr && is_rrf && dest |=> carry_q == $past(src_val[0]) &&
         file_mem[$past(f)] == {$past(carry_q), $past(src_val[7:1])})
      else $error("rotate right to file result or carry wrong");

   AST_RLF_FILE: assert property (
      instr_wr && is_rlf && dest |=> carry_q == $past(src_val[7]) &&
         file_mem[$past(f)] == {$past(src_val[6:0]), $past(carry_q)})
      else $error("rotate left to file result or carry wrong");

   AST_SRC_KEPT: assert property (
      instr_wr && is_rot && !dest |=> file_mem[$past(f)] == $past(src_val))
      else $error("rotate to accumulator disturbed the source");

   AST_SLEEP_ENTER: assert property (
      instr_wr && is_sleep |=> sleep_o && state_q == rse_pkg::ST_SLEEP)
      else $error("sleep instruction did not halt the core");

   COV_RRF_FILE: cover property (instr_wr && is_rrf && dest);
   COV_RLF_W:    cover property (instr_wr && is_rlf && !dest);
   COV_RRF_W:    cover property (instr_wr && is_rrf && !dest);
   COV_RLF_FILE: cover property (instr_wr && is_rlf && dest);
   COV_SLEEP_WAKE: cover property (instr_wr && is_sleep ##[1:50] !sleep_o);

endmodule
`default_nettype wire

/* hw/rse_pkg.sv */
// Summary of operation
// - Rotate-right moves the addressed register one place toward bit 0, old carry into bit 7, old bit 0 into carry, no other flag touched.
// - Rotate-left moves the addressed register one place toward bit 7, old carry into bit 0, old bit 7 into carry, no other flag touched.
// - With destination select 0 a rotate result goes to the working accumulator and the source register is left as it was.
// - With destination select 1 a rotate result goes back into the register picked by the 7-bit file address, 0 to 127.
// - The sleep opcode zeroes the watchdog counter and its prescaler, sets the timeout status bit and clears the power-down status bit.
`default_nettype none
package rse_pkg;

   // Bus geometry
   localparam int unsigned ADDR_W = 5;
   localparam int unsigned DATA_W = 32;

   // Register byte offsets
   localparam logic [4:0] OFS_INSTR  = 5'h00;
   localparam logic [4:0] OFS_WREG   = 5'h04;
   localparam logic [4:0] OFS_STATUS = 5'h08;
   localparam logic [4:0] OFS_WDOG   = 5'h0c;
   localparam logic [4:0] OFS_SLEEP  = 5'h10;
   localparam logic [4:0] OFS_FADDR  = 5'h14;
   localparam logic [4:0] OFS_FDATA  = 5'h18;
   localparam logic [4:0] OFS_ERR    = 5'h1c;

   // Status field positions and reset values
   localparam int unsigned ST_CARRY   = 0;
   localparam int unsigned ST_PDOWN   = 3;
   localparam int unsigned ST_TIMEOUT = 4;
   localparam logic        RST_CARRY   = 1'b0;
   localparam logic        RST_PDOWN   = 1'b1;
   localparam logic        RST_TIMEOUT = 1'b1;

   // Error flag positions
   localparam int unsigned ERR_BADOP   = 0;
   localparam int unsigned ERR_ASLEEP  = 1;

   // Instruction word layout
   localparam int unsigned OPC_W      = 14;
   localparam int unsigned OPC_HI_POS = 8;
   localparam int unsigned DEST_POS   = 7;
   localparam int unsigned FADR_W     = 7;
   localparam logic [5:0]  OPC_RRF    = 6'h0c;
   localparam logic [5:0]  OPC_RLF    = 6'h0d;
   localparam logic [13:0] OPC_SLEEP  = 14'h0063;

   // Reset values of data registers
   localparam logic [7:0]  RST_WREG  = 8'h00;
   localparam logic [6:0]  RST_FADDR = 7'h00;
   localparam logic [13:0] RST_INSTR = 14'h0000;

   // Core run state
   typedef enum logic {
      ST_RUN,
      ST_SLEEP
   } rse_state_type;

endpackage
`default_nettype wire

/* tb/rse_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module testbench;
   logic                         clk_i;
   logic                         rstn_i;
   logic [rse_pkg::ADDR_W-1:0]   address_i;
   logic                         read_i;
   logic                         write_i;
   logic [rse_pkg::DATA_W-1:0]   writedata_i;
   logic [3:0]                   byteenable_i;
   logic [rse_pkg::DATA_W-1:0]   readdata_o;
   logic                         waitrequest_o;
   logic                         wake_i;
   logic                         sleep_o;
   logic                         exec_done_o;
   int                           n_errors;
   int                           tests_run;
   int                           n_exec = 0;
   logic [31:0]                  rd;

   rse_exec rse_exec_i (
      .clk_i         (clk_i),
      .rstn_i        (rstn_i),
      .address_i     (address_i),
      .read_i        (read_i),
      .write_i       (write_i),
      .writedata_i   (writedata_i),
      .byteenable_i  (byteenable_i),
      .readdata_o    (readdata_o),
      .waitrequest_o (waitrequest_o),
      .wake_i        (wake_i),
      .sleep_o       (sleep_o),
      .exec_done_o   (exec_done_o)
   );

   // Free-running 125 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   // Count completion pulses; the pulse is one cycle, so each edge counts once
   always @(posedge clk_i) begin
      if (exec_done_o === 1'b1) n_exec <= n_exec + 1;
   end

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus_wr(input logic [4:0] a, input logic [31:0] d);
      @(posedge clk_i);
      address_i <= a;
      writedata_i <= d;
      write_i <= 1'b1;
      do @(posedge clk_i); while (waitrequest_o !== 1'b0);
      write_i <= 1'b0;
   endtask

   task automatic bus_rd(input logic [4:0] a, output logic [31:0] d);
      @(posedge clk_i);
      address_i <= a;
      read_i <= 1'b1;
      do @(posedge clk_i); while (waitrequest_o !== 1'b0);
      d = readdata_o;
      read_i <= 1'b0;
   endtask

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic rd_check(input string name, input logic [4:0] a, input logic [31:0] exp);
      bus_rd(a, rd);
      check(name, exp, rd);
   endtask

   // Hang guard: the whole sequence needs well under a thousand cycles
   initial begin
      #40000;
      n_errors++;
      $display("ERROR watchdog expected end seen hang");
      conclude();
   end

   initial begin
      rstn_i = 1'b0;
      address_i = 5'h00;
      read_i = 1'b0;
      write_i = 1'b0;
      writedata_i = 32'h0000_0000;
      byteenable_i = 4'hf;
      wake_i = 1'b0;
      n_errors = 0;
      tests_run = 0;
      repeat (5) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd_check("status_reset", rse_pkg::OFS_STATUS, 32'h0000_0018);
      rd_check("w_reset", rse_pkg::OFS_WREG, 32'h0000_0000);
      $display("test reset done");
      // Rotate right into W, source kept, carry from bit 0
      bus_wr(rse_pkg::OFS_FADDR, 32'h0000_0005);
      bus_wr(rse_pkg::OFS_FDATA, 32'h0000_00e6);
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_0c05);
      rd_check("w_rrf", rse_pkg::OFS_WREG, 32'h0000_0073);
      rd_check("file_rrf", rse_pkg::OFS_FDATA, 32'h0000_00e6);
      rd_check("status_rrf", rse_pkg::OFS_STATUS, 32'h0000_0018);
      // Rotate left into W with carry set beforehand
      bus_wr(rse_pkg::OFS_STATUS, 32'h0000_0001);
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_0d05);
      rd_check("w_rlf", rse_pkg::OFS_WREG, 32'h0000_00cd);
      rd_check("status_rlf", rse_pkg::OFS_STATUS, 32'h0000_0019);
      rd_check("file_rlf", rse_pkg::OFS_FDATA, 32'h0000_00e6);
      $display("test rotate to w done");
      // Rotates back into the top file location, carry cleared first
      bus_wr(rse_pkg::OFS_STATUS, 32'h0000_0000);
      bus_wr(rse_pkg::OFS_FADDR, 32'h0000_007f);
      bus_wr(rse_pkg::OFS_FDATA, 32'h0000_0001);
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_0cff);
      rd_check("file_rrf_d1", rse_pkg::OFS_FDATA, 32'h0000_0000);
      rd_check("carry_rrf_d1", rse_pkg::OFS_STATUS, 32'h0000_0019);
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_0dff);
      rd_check("file_rlf_d1", rse_pkg::OFS_FDATA, 32'h0000_0001);
      rd_check("carry_rlf_d1", rse_pkg::OFS_STATUS, 32'h0000_0018);
      rd_check("w_kept_d1", rse_pkg::OFS_WREG, 32'h0000_00cd);
      $display("test rotate to file done");
      // Sleep after the watchdog has run for a few hundred cycles
      repeat (300) @(posedge clk_i);
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_0063);
      bus_rd(rse_pkg::OFS_WDOG, rd);
      check("wdog_count", 32'h0000_0000, {24'h000000, rd[7:0]});
      check("wdog_pre_small", 32'h0000_0000, {24'h000000, rd[15:12], 4'h0});
      rd_check("status_sleep", rse_pkg::OFS_STATUS, 32'h0000_0010);
      check("sleep_level", 32'h0000_0001, {31'h0, sleep_o});
      check("exec_pulses", 32'h0000_0005, n_exec);
      // Instruction issued while asleep is refused
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_0c05);
      rd_check("err_asleep", rse_pkg::OFS_ERR, 32'h0000_0002);
      rd_check("w_asleep", rse_pkg::OFS_WREG, 32'h0000_00cd);
      bus_wr(rse_pkg::OFS_SLEEP, 32'h0000_0000);
      rd_check("sleep_reg_wake", rse_pkg::OFS_SLEEP, 32'h0000_0000);
      $display("test sleep done");
      // Wake through the external event
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_0063);
      // Sleep level is launched by the commit edge, so look one edge later
      @(posedge clk_i);
      check("sleep_again", 32'h0000_0001, {31'h0, sleep_o});
      wake_i <= 1'b1;
      for (int i = 0; i < 20 && sleep_o !== 1'b0; i++) @(posedge clk_i);
      wake_i <= 1'b0;
      check("wake_pin", 32'h0000_0000, {31'h0, sleep_o});
      rd_check("status_wake", rse_pkg::OFS_STATUS, 32'h0000_0010);
      // Unknown opcode flagged, then both error bits cleared
      bus_wr(rse_pkg::OFS_INSTR, 32'h0000_3fff);
      rd_check("err_badop", rse_pkg::OFS_ERR, 32'h0000_0003);
      bus_wr(rse_pkg::OFS_ERR, 32'h0000_0003);
      rd_check("err_clear", rse_pkg::OFS_ERR, 32'h0000_0000);
      rd_check("w_badop", rse_pkg::OFS_WREG, 32'h0000_00cd);
      $display("test wake and error done");
      conclude();
   end
endmodule
`default_nettype wire
